// >>> fsp_pkg.sv
// Constants for the fast shutdown priority block
package fsp_pkg;
  localparam int NUM_CH = 2;
  localparam int PRIO_W = 3;
  localparam int PRIO_LSB_STEP = 4;
  localparam int REG_W = 8;
  localparam logic [7:0] PRIO_REG_ADDR = 8'h28;
  localparam logic [7:0] PRIO_REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
endpackage : fsp_pkg

// >>> fsp_top.sv
// Channel 3/4 fast shutdown priority register and shutdown decision
// How it works
// - Each channel holds a 3-bit priority, used only when multi-level select is set.
// - Register 0x28: channel 4 in bits 6:4, channel 3 in bits 2:0, RW, reset 0.
// - Code less than or equal to channel priority powers that channel off.
// - Code greater than channel priority leaves the channel untouched.
// - Code shutdown runs the channel reset clearing but keeps cool-down timers running.
// - Channels sharing a priority value all drop together on a qualifying code.
// - Four-pair halves decide alone; host gives both the same priority.
// - After a code shutdown, power-on repowers if detect/class valid and allocation fits.
// - Shutdown clears done events, disconnect, cut, start, limit and four-pair cut faults.
// - Shutdown clears status, enables, autoclass, class change, fault, four-pair, foldback.
// - Shutdown zeroes voltage, current, detect resistance/capacitance and autoclass readings.
// - Shutdown clears requested class, detection results, assigned and previous class.
// - No memory of earlier codes; each code judged alone against current priorities.
// - Each code acts at once, one clock after it is delivered.
`timescale 1ns/1ps
module fsp_top (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // Register command port
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [fsp_pkg::REG_W-1:0] REG_WDATA_IN,
  output logic [fsp_pkg::REG_W-1:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  // Shutdown code from the serial receiver
  input wire logic MULTI_LEVEL_SHUTDOWN_SELECT_IN,
  input wire logic FAST_SHUTDOWN_VALID_IN,
  input wire logic [fsp_pkg::PRIO_W-1:0] FAST_SHUTDOWN_CODE_IN,
  // Per-channel commands and qualifiers
  input wire logic [fsp_pkg::NUM_CH-1:0] CHAN_RESET_CMD_IN,
  input wire logic [fsp_pkg::NUM_CH-1:0] POWER_ON_COMMAND_IN,
  input wire logic [fsp_pkg::NUM_CH-1:0] DET_CLASS_VALID_IN,
  input wire logic [fsp_pkg::NUM_CH-1:0] ALLOC_SUFFICIENT_IN,
  // Per-channel results
  output logic [fsp_pkg::NUM_CH-1:0] SHUTDOWN_HIT_OUT,
  output logic [fsp_pkg::NUM_CH-1:0] CLEAR_EVENTS_OUT,
  output logic [fsp_pkg::NUM_CH-1:0] CLEAR_STATUS_OUT,
  output logic [fsp_pkg::NUM_CH-1:0] CLEAR_MEAS_OUT,
  output logic [fsp_pkg::NUM_CH-1:0] CLEAR_CLASS_OUT,
  output logic [fsp_pkg::NUM_CH-1:0] COOLDOWN_CANCEL_OUT,
  output logic [fsp_pkg::NUM_CH-1:0] POWER_ON_OUT,
  output logic [fsp_pkg::NUM_CH-1:0] CHAN_POWERED_OUT
);
  import fsp_pkg::*;

  logic [REG_W-1:0] prio_reg_q;
  logic [REG_W-1:0] prio_reg_d;
  logic [REG_W-1:0] rdata_q;
  logic [REG_W-1:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [NUM_CH-1:0] hit_q;
  logic [NUM_CH-1:0] hit_d;
  logic [NUM_CH-1:0] clr_q;
  logic [NUM_CH-1:0] clr_d;
  logic [NUM_CH-1:0] cancel_q;
  logic [NUM_CH-1:0] cancel_d;
  logic [NUM_CH-1:0] pon_q;
  logic [NUM_CH-1:0] pon_d;
  logic [NUM_CH-1:0] powered_q;
  logic [NUM_CH-1:0] powered_d;
  logic [NUM_CH-1:0] qualify;
  logic addr_hit;

  assign addr_hit = (REG_ADDR_IN == PRIO_REG_ADDR);

  // Register file
  always_comb begin
    prio_reg_d = prio_reg_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (REG_WR_IN && addr_hit) begin
      prio_reg_d = REG_WDATA_IN;
    end
    if (REG_RD_IN) begin
      rvalid_d = 1'b1;
      rdata_d = addr_hit ? prio_reg_q : UNMAPPED_RDATA;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      prio_reg_q <= PRIO_REG_RESET;
      rdata_q <= UNMAPPED_RDATA;
      rvalid_q <= 1'b0;
    end else begin
      prio_reg_q <= prio_reg_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Per-channel priority compare
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      logic [PRIO_W-1:0] prio;
      assign prio = prio_reg_q[i*PRIO_LSB_STEP +: PRIO_W];
      // Code <= priority drops the channel; only with multi-level select
      assign qualify[i] = MULTI_LEVEL_SHUTDOWN_SELECT_IN && FAST_SHUTDOWN_VALID_IN
                          && (FAST_SHUTDOWN_CODE_IN <= prio);
    end
  endgenerate

  // Channel actions
  always_comb begin
    hit_d = qualify;
    clr_d = qualify | CHAN_RESET_CMD_IN;
    cancel_d = CHAN_RESET_CMD_IN;
    pon_d = POWER_ON_COMMAND_IN & DET_CLASS_VALID_IN & ALLOC_SUFFICIENT_IN
            & ~clr_d;
    powered_d = (powered_q | pon_d) & ~clr_d;
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      hit_q <= '0;
      clr_q <= '0;
      cancel_q <= '0;
      pon_q <= '0;
      powered_q <= '0;
    end else begin
      hit_q <= hit_d;
      clr_q <= clr_d;
      cancel_q <= cancel_d;
      pon_q <= pon_d;
      powered_q <= powered_d;
    end
  end

  assign REG_RDATA_OUT = rdata_q;
  assign REG_RVALID_OUT = rvalid_q;
  assign SHUTDOWN_HIT_OUT = hit_q;
  assign CLEAR_EVENTS_OUT = clr_q;
  assign CLEAR_STATUS_OUT = clr_q;
  assign CLEAR_MEAS_OUT = clr_q;
  assign CLEAR_CLASS_OUT = clr_q;
  assign COOLDOWN_CANCEL_OUT = cancel_q;
  assign POWER_ON_OUT = pon_q;
  assign CHAN_POWERED_OUT = powered_q;

  // Checks
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_code_drops_ch3;
    MULTI_LEVEL_SHUTDOWN_SELECT_IN && FAST_SHUTDOWN_VALID_IN
      && (FAST_SHUTDOWN_CODE_IN <= prio_reg_q[2:0]);
  endsequence

  sequence s_ch3_cleared;
    SHUTDOWN_HIT_OUT[0] && CLEAR_EVENTS_OUT[0] && CLEAR_MEAS_OUT[0] && !CHAN_POWERED_OUT[0];
  endsequence

  property p_reg_write;
    REG_WR_IN && addr_hit |=> prio_reg_q == $past(REG_WDATA_IN);
  endproperty
  a_reg_write: assert property (p_reg_write) else $error("priority register write lost");

  property p_reg_read;
    REG_RD_IN && addr_hit && !REG_WR_IN |=> REG_RVALID_OUT && REG_RDATA_OUT == $past(prio_reg_q);
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("priority register read wrong");

  property p_ch3_drop;
    s_code_drops_ch3 |=> s_ch3_cleared;
  endproperty
  a_ch3_drop: assert property (p_ch3_drop) else $error("channel 3 not shut by code");

  property p_ch4_drop;
    MULTI_LEVEL_SHUTDOWN_SELECT_IN && FAST_SHUTDOWN_VALID_IN
      && FAST_SHUTDOWN_CODE_IN <= prio_reg_q[6:4] |=> SHUTDOWN_HIT_OUT[1] && CLEAR_CLASS_OUT[1];
  endproperty
  a_ch4_drop: assert property (p_ch4_drop) else $error("channel 4 not shut by code");

  property p_ch3_spared;
    FAST_SHUTDOWN_VALID_IN && FAST_SHUTDOWN_CODE_IN > prio_reg_q[2:0] && !CHAN_RESET_CMD_IN[0]
      |=> !SHUTDOWN_HIT_OUT[0] && !CLEAR_STATUS_OUT[0];
  endproperty
  a_ch3_spared: assert property (p_ch3_spared) else $error("ch3 hit by higher code");

  property p_lowest;
    MULTI_LEVEL_SHUTDOWN_SELECT_IN && FAST_SHUTDOWN_VALID_IN && prio_reg_q[6:4] == 3'h7
      |=> SHUTDOWN_HIT_OUT[1];
  endproperty
  a_lowest: assert property (p_lowest) else $error("lowest priority not dropped");

  property p_no_cancel;
    SHUTDOWN_HIT_OUT != 2'h0 && !$past(CHAN_RESET_CMD_IN[0]) && !$past(CHAN_RESET_CMD_IN[1])
      |-> COOLDOWN_CANCEL_OUT == 2'h0;
  endproperty
  a_no_cancel: assert property (p_no_cancel) else $error("cool-down cancelled by code");

  property p_reset_cmd;
    CHAN_RESET_CMD_IN[1]
      |=> COOLDOWN_CANCEL_OUT[1] && CLEAR_EVENTS_OUT[1] && !CHAN_POWERED_OUT[1];
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command did not clear");

  property p_shared;
    MULTI_LEVEL_SHUTDOWN_SELECT_IN && FAST_SHUTDOWN_VALID_IN
      && prio_reg_q[2:0] == prio_reg_q[6:4] && FAST_SHUTDOWN_CODE_IN <= prio_reg_q[2:0]
      |=> SHUTDOWN_HIT_OUT == 2'h3;
  endproperty
  a_shared: assert property (p_shared) else $error("shared priority not dropped");

  property p_repower;
    POWER_ON_COMMAND_IN[0] && DET_CLASS_VALID_IN[0] && ALLOC_SUFFICIENT_IN[0]
      && !qualify[0] && !CHAN_RESET_CMD_IN[0] |=> POWER_ON_OUT[0] && CHAN_POWERED_OUT[0];
  endproperty
  a_repower: assert property (p_repower) else $error("power-on not honoured");

  property p_no_memory;
    !FAST_SHUTDOWN_VALID_IN |=> SHUTDOWN_HIT_OUT == 2'h0;
  endproperty
  a_no_memory: assert property (p_no_memory) else $error("shutdown without a code");

  property p_unselected;
    !MULTI_LEVEL_SHUTDOWN_SELECT_IN |=> SHUTDOWN_HIT_OUT == 2'h0;
  endproperty
  a_unselected: assert property (p_unselected) else $error("code without select");

  property p_stays_off;
    $fell(CHAN_POWERED_OUT[0]) |-> !POWER_ON_OUT[0];
  endproperty
  a_stays_off: assert property (p_stays_off) else $error("channel 3 repowered while off");

  property p_reset_values;
    $fell(RST_IN) |-> prio_reg_q == PRIO_REG_RESET && SHUTDOWN_HIT_OUT == 2'h0
      && CHAN_POWERED_OUT == 2'h0 && !REG_RVALID_OUT;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset state wrong");

  property p_ch4_spared;
    FAST_SHUTDOWN_VALID_IN && FAST_SHUTDOWN_CODE_IN > prio_reg_q[6:4] && !CHAN_RESET_CMD_IN[1]
      |=> !SHUTDOWN_HIT_OUT[1] && !CLEAR_EVENTS_OUT[1];
  endproperty
  a_ch4_spared: assert property (p_ch4_spared) else $error("ch4 hit by higher code");

  property p_highest;
    FAST_SHUTDOWN_VALID_IN && prio_reg_q[2:0] == 3'h0 && FAST_SHUTDOWN_CODE_IN != 3'h0
      |=> !SHUTDOWN_HIT_OUT[0];
  endproperty
  a_highest: assert property (p_highest) else $error("highest priority dropped");

  property p_cancel_cause;
    COOLDOWN_CANCEL_OUT != 2'h0 |-> COOLDOWN_CANCEL_OUT == $past(CHAN_RESET_CMD_IN);
  endproperty
  a_cancel_cause: assert property (p_cancel_cause) else $error("cancel without reset");

  property p_clear_cause;
    CLEAR_STATUS_OUT != 2'h0 |-> CLEAR_STATUS_OUT == (SHUTDOWN_HIT_OUT | COOLDOWN_CANCEL_OUT);
  endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("clear without cause");

  property p_hit_events;
    (SHUTDOWN_HIT_OUT & ~CLEAR_EVENTS_OUT) == 2'h0;
  endproperty
  a_hit_events: assert property (p_hit_events) else $error("events not cleared");

  property p_hit_meas;
    (SHUTDOWN_HIT_OUT & ~CLEAR_MEAS_OUT) == 2'h0;
  endproperty
  a_hit_meas: assert property (p_hit_meas) else $error("readings not zeroed");

  property p_hit_class;
    (SHUTDOWN_HIT_OUT & ~CLEAR_CLASS_OUT) == 2'h0;
  endproperty
  a_hit_class: assert property (p_hit_class) else $error("class not cleared");

  property p_grant_ok;
    POWER_ON_OUT[1] |-> $past(POWER_ON_COMMAND_IN[1]) && $past(DET_CLASS_VALID_IN[1])
      && $past(ALLOC_SUFFICIENT_IN[1]);
  endproperty
  a_grant_ok: assert property (p_grant_ok) else $error("grant not qualified");

  property p_refuse_grant;
    POWER_ON_COMMAND_IN[1] && !DET_CLASS_VALID_IN[1] |=> !POWER_ON_OUT[1];
  endproperty
  a_refuse_grant: assert property (p_refuse_grant) else $error("unqualified grant");

  sequence s_grant_ch4;
    POWER_ON_COMMAND_IN[1] && DET_CLASS_VALID_IN[1] && ALLOC_SUFFICIENT_IN[1]
      && !qualify[1] && !CHAN_RESET_CMD_IN[1];
  endsequence

  sequence s_ch4_powered;
    POWER_ON_OUT[1] && CHAN_POWERED_OUT[1];
  endsequence

  property p_repower_ch4;
    s_grant_ch4 |=> s_ch4_powered;
  endproperty
  a_repower_ch4: assert property (p_repower_ch4) else $error("ch4 not repowered");

  property p_powered_holds;
    CHAN_POWERED_OUT[1] && !qualify[1] && !CHAN_RESET_CMD_IN[1] |=> CHAN_POWERED_OUT[1];
  endproperty
  a_powered_holds: assert property (p_powered_holds) else $error("ch4 dropped");

  property p_rvalid_cause;
    REG_RVALID_OUT |-> $past(REG_RD_IN);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");

  property p_unmapped_read;
    REG_RD_IN && !addr_hit |=> REG_RDATA_OUT == UNMAPPED_RDATA;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("bad unmapped read");

  property p_foreign_write;
    REG_WR_IN && !addr_hit |=> prio_reg_q == $past(prio_reg_q);
  endproperty
  a_foreign_write: assert property (p_foreign_write) else $error("foreign write stored");

  property p_rdata_holds;
    !REG_RD_IN |=> $stable(REG_RDATA_OUT);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");

endmodule // fsp_top

// >>> fsp_host_model.sv
// Host model driving registers, shutdown codes and channel commands
`timescale 1ns/1ps
module fsp_host_model (
  // Clock
  input wire logic clk_in,
  // Toward the block
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic sel_out,
  output logic vld_out,
  output logic [2:0] code_out,
  output logic [1:0] rcmd_out,
  output logic [1:0] pon_out,
  output logic [1:0] dv_out,
  output logic [1:0] al_out
);
  initial {wr_out, rd_out, addr_out, wdata_out, sel_out, vld_out, code_out, rcmd_out,
    pon_out, dv_out, al_out} = '0;
  // Released strobes go low; address and data lines carry the inverse of their last value
  task automatic reg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    {wr_out, rd_out, addr_out, wdata_out} = {w, !w, a, d};
    @(negedge clk_in);
    {wr_out, rd_out, addr_out, wdata_out} = {2'b00, ~a, ~d};
  endtask
  // One code per call; with select set, a code drops every channel whose priority is at or above it
  task automatic send_code(input logic s, input logic [2:0] c);
    @(negedge clk_in);
    {sel_out, vld_out, code_out} = {s, 1'b1, c};
    @(negedge clk_in);
    {vld_out, code_out} = {1'b0, ~c};
  endtask
  task automatic chan_cmd(input logic [1:0] r, p, v, a);
    @(negedge clk_in);
    {rcmd_out, pon_out, dv_out, al_out} = {r, p, v, a};
    @(negedge clk_in);
    {rcmd_out, pon_out} = 4'h0;
  endtask
endmodule // fsp_host_model

// >>> testbench.sv
// Self-checking bench for the shutdown priority block
`timescale 1ns/1ps
module testbench;
  import fsp_pkg::*;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
  logic clk, rst, wr, rd, sel, vld, rvalid;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] code;
  logic [1:0] rcmd, pon, dv, al, hit, ce, cs, cm, cc, cx, po, pw;
  int mismatches, n_tests;
  logic [7:0] rq[$];
  logic [13:0] eq[$];
  logic [13:0] ov;
  assign ov = {hit, ce, cs, cm, cc, cx, po};
  fsp_top u_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .MULTI_LEVEL_SHUTDOWN_SELECT_IN(sel), .FAST_SHUTDOWN_VALID_IN(vld),
    .FAST_SHUTDOWN_CODE_IN(code), .CHAN_RESET_CMD_IN(rcmd), .POWER_ON_COMMAND_IN(pon),
    .DET_CLASS_VALID_IN(dv), .ALLOC_SUFFICIENT_IN(al), .SHUTDOWN_HIT_OUT(hit),
    .CLEAR_EVENTS_OUT(ce), .CLEAR_STATUS_OUT(cs), .CLEAR_MEAS_OUT(cm), .CLEAR_CLASS_OUT(cc),
    .COOLDOWN_CANCEL_OUT(cx), .POWER_ON_OUT(po), .CHAN_POWERED_OUT(pw));
  fsp_host_model u_host (.clk_in(clk), .wr_out(wr), .rd_out(rd), .addr_out(addr),
    .wdata_out(wdata), .sel_out(sel), .vld_out(vld), .code_out(code), .rcmd_out(rcmd),
    .pon_out(pon), .dv_out(dv), .al_out(al));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic test_done();
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #125000;
    mismatches++;
    test_done();
  end
  // A read answer or any nonzero result other than powered state takes the oldest note
  always @(negedge clk) begin : mon
    logic [7:0] er;
    logic [13:0] ee;
    if (rvalid !== 1'b0) begin
      er = rq.size() ? rq.pop_front() : 8'hXX;
      `CHK(rdata, er)
    end
    if (ov !== 14'h0) begin
      ee = eq.size() ? eq.pop_front() : 14'hXXXX;
      `CHK(ov, ee)
    end
  end
  initial begin : main
    logic [2:0] p3, p4, c;
    logic [1:0] h;
    rst = 1'b1;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(64588));
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rq.push_back(PRIO_REG_RESET);
    u_host.reg_op(1'b0, PRIO_REG_ADDR, 8'h00);
    rq.push_back(UNMAPPED_RDATA);
    u_host.reg_op(1'b0, 8'h27, 8'h00);
    for (int i = 0; i < 16; i++) begin
      p3 = (i < 2) ? 3'h0 : 3'($urandom);
      p4 = (i == 0) ? 3'h7 : (i[0] ? p3 : 3'($urandom));
      c = (i < 8) ? 3'(i) : p3;
      h = {c <= p4, c <= p3};
      u_host.reg_op(1'b1, PRIO_REG_ADDR, {1'b0, p4, 1'b0, p3});
      if (h != 2'b00) eq.push_back({h, h, h, h, h, 4'h0});
      u_host.send_code(1'b1, c);
    end
    u_host.reg_op(1'b1, PRIO_REG_ADDR, 8'hFF);
    u_host.reg_op(1'b1, 8'h27, 8'h00);
    u_host.send_code(1'b0, 3'h0);
    rq.push_back(8'hFF);
    u_host.reg_op(1'b0, PRIO_REG_ADDR, 8'h00);
    eq.push_back({2'b00, {5{2'b11}}, 2'b00});
    u_host.chan_cmd(2'b11, 2'b00, 2'b11, 2'b11);
    eq.push_back({12'h000, 2'b11});
    u_host.chan_cmd(2'b00, 2'b11, 2'b11, 2'b11);
    `CHK(pw, 2'b11)
    eq.push_back({{5{2'b11}}, 4'h0});
    u_host.send_code(1'b1, 3'h7);
    `CHK(pw, 2'b00)
    eq.push_back({12'h000, 2'b01});
    u_host.chan_cmd(2'b00, 2'b11, 2'b01, 2'b11);
    eq.push_back({12'h000, 2'b10});
    u_host.chan_cmd(2'b00, 2'b11, 2'b11, 2'b10);
    `CHK(pw, 2'b11)
    repeat (4) @(negedge clk);
    `CHK(eq.size() + rq.size(), 0)
    test_done();
  end
endmodule // testbench
